// File: pkg/ocd_cfg_if.sv
// carries the stored configuration word between store and decoder
`timescale 1ns/1ps
interface ocd_cfg_if;
    logic [15:0] word;
    logic        locked;
    modport store (output word, output locked);
    modport user  (input word, input locked);
endinterface

// File: pkg/ocd_pkg.sv
// option configuration word constants and field positions
package ocd_pkg;
    localparam int          CFG_W          = 16;
    localparam logic [15:0] CFG_RESET      = 16'h0000;
    localparam logic [15:0] CFG_RSVD_MASK  = 16'hfc30;
    localparam logic [15:0] CFG_FACTORY    = 16'h0000;
    localparam int          BIT_EXT_STOP   = 9;
    localparam int          BIT_LOW_VOLT   = 8;
    localparam int          BIT_PROTECT    = 7;
    localparam int          BIT_OSC_RC     = 6;
    localparam int          BIT_NMI_PULL   = 3;
    localparam int          BIT_TIMER_PULL = 2;
    localparam int          BIT_HW_WDG     = 1;
    localparam int          BIT_SAFEGUARD  = 0;
    localparam logic [1:0]  ADDR_LSB       = 2'h0;
    localparam logic [1:0]  ADDR_MSB       = 2'h1;
    typedef enum logic [1:0] {
        OCD_BLANK  = 2'b00,
        OCD_LOW    = 2'b01,
        OCD_LOCKED = 2'b11
    } ocd_state_t;
endpackage

// File: verification/ocd_option_decoder_tb_top.sv
// randomised bench for the option configuration decoder
`timescale 1ns/1ps
module ocd_option_decoder_tb_top;
    import ocd_pkg::*;
    logic        i_core_clk = 1'b0, i_rst_n = 1'b0, i_nmi_pin = 1'b0, i_wdg_active = 1'b0;
    logic        md, wr, rd, lk, stp;
    logic [1:0]  ad, ba;
    logic [7:0]  wd, bd, rdata, ex;
    logic [6:0]  dec;
    logic [15:0] w, seed;
    int          mismatches = 0, samples_checked = 0;
    always #25 i_core_clk = ~i_core_clk;
    ocd_prog_tool ocd_prog_tool_inst (.i_core_clk(i_core_clk), .o_mode(md), .o_wr(wr),
        .o_rd(rd), .o_addr(ad), .o_wdata(wd));
    ocd_option_decoder ocd_option_decoder_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_prog_mode(md), .i_prog_wr(wr), .i_prog_rd(rd), .i_prog_addr(ad),
        .i_prog_wdata(wd), .i_nmi_pin(i_nmi_pin), .i_wdg_active(i_wdg_active),
        .o_prog_rdata(rdata), .o_cfg_locked(lk), .o_stop_allowed(stp),
        .o_low_volt_detect_en(dec[6]), .o_readout_protect(dec[5]), .o_osc_rc_sel(dec[4]),
        .o_nmi_pin_pullup_en(dec[3]), .o_timer_pin_pullup_en(dec[2]),
        .o_hw_watchdog_sel(dec[1]), .o_osc_safeguard_en(dec[0]));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] exp_out(input logic [15:0] v, input logic n, input logic g);
        return {!(g | v[1]) | (v[9] & n), v[8], v[7], v[6], v[3:0]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        chk({8'h00, got}, {8'h00, exp});
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        seed = 16'h004e;
        for (int n = 0; n < 12; n++) begin
            @(posedge i_core_clk);
            seed = lfsr(seed);
            w = (n == 0) ? CFG_RESET : (n == 1) ? 16'h03cf : seed & ~CFG_RSVD_MASK;
            i_rst_n <= 1'b0;
            i_nmi_pin <= seed[3];
            i_wdg_active <= seed[5];
            repeat (2) @(posedge i_core_clk);
            i_rst_n <= 1'b1;
            @(posedge i_core_clk);
            #1 chk({lk, dec}, 16'h0000);
            // out of mode, high first, good pair, then an ignored rewrite
            for (int k = 0; k < 7; k++) begin
                if (k == 2) ocd_prog_tool_inst.o_mode <= 1'b1;
                ba = (7'b1010110 >> k) & 1 ? ADDR_MSB : ADDR_LSB;
                bd = (ba == ADDR_MSB) ? w[15:8] : w[7:0];
                ocd_prog_tool_inst.xfer(1'b1, ba, (7'b1100111 >> k) & 1 ? ~bd : bd);
            end
            repeat (4) @(posedge i_core_clk);
            ex = exp_out(w, seed[3], seed[5]);
            #1 chk({lk, stp, dec}, {1'b1, ex});
            chk(dec[3:0], {w[3], w[2], w[1], w[0]});
            ocd_prog_tool_inst.xfer(1'b0, ADDR_LSB, 8'h00);
            #1 chk_rd(rdata, w[7:0]);
            ocd_prog_tool_inst.xfer(1'b0, ADDR_MSB, 8'h00);
            #1 chk_rd(rdata, w[15:8]);
            @(posedge i_core_clk) ocd_prog_tool_inst.o_mode <= 1'b0;
            ocd_prog_tool_inst.xfer(1'b0, ADDR_LSB, 8'h00);
            #1 chk_rd(rdata, 8'h00);
            $display("word %h done", w);
        end
        results();
    end
endmodule

// File: verification/ocd_prog_tool.sv
// programming tool model driving the option word port
`timescale 1ns/1ps
module ocd_prog_tool (
    input  logic       i_core_clk,
    output logic       o_mode,
    output logic       o_wr,
    output logic       o_rd,
    output logic [1:0] o_addr,
    output logic [7:0] o_wdata
);
    initial {o_mode, o_wr, o_rd, o_addr, o_wdata} = 13'h065;
    task automatic xfer(input logic w, input logic [1:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        o_wr <= w;
        o_rd <= !w;
        o_addr <= a;
        o_wdata <= d & ((a == 2'h1) ? 8'h03 : 8'hcf);
        @(posedge i_core_clk);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        o_wdata <= ~d; // released lines do not keep the last value
    endtask
endmodule

// File: verification/ocd_props.sv
// assertions on the option decoder ports
`timescale 1ns/1ps
module ocd_props (
    input logic       i_core_clk,
    input logic       i_rst_n,
    input logic       i_prog_mode,
    input logic       i_prog_rd,
    input logic [1:0] i_prog_addr,
    input logic       i_nmi_pin,
    input logic       i_wdg_active,
    input logic [7:0] o_prog_rdata,
    input logic       o_cfg_locked,
    input logic       o_stop_allowed,
    input logic       o_low_volt_detect_en,
    input logic       o_readout_protect,
    input logic       o_osc_rc_sel,
    input logic       o_nmi_pin_pullup_en,
    input logic       o_timer_pin_pullup_en,
    input logic       o_hw_watchdog_sel,
    input logic       o_osc_safeguard_en
);
    wire logic [5:0] lo = {o_readout_protect, o_osc_rc_sel, o_nmi_pin_pullup_en,
                           o_timer_pin_pullup_en, o_hw_watchdog_sel, o_osc_safeguard_en};
    wire logic       rq = i_prog_rd && i_prog_mode && o_cfg_locked;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    property p_lock_hold; o_cfg_locked |=> o_cfg_locked; endproperty
    property p_static; o_cfg_locked |=> $stable({lo, o_low_volt_detect_en}); endproperty
    property p_low_volt_lock; o_low_volt_detect_en |-> o_cfg_locked; endproperty
    property p_rd_idle; !$past(i_prog_rd) |-> o_prog_rdata == 8'h00; endproperty
    property p_rd_gate; i_prog_rd && !i_prog_mode |=> o_prog_rdata == 8'h00; endproperty
    property p_rd_lo; rq && i_prog_addr == 2'h0 |=> o_prog_rdata == {lo[5:4], 2'b00, lo[3:0]};
    endproperty
    // bit 9 only shows through stop, so bit 1 of the high byte is not checked here
    property p_rd_hi; rq && i_prog_addr == 2'h1 |=> o_prog_rdata[7:2] == 6'h00
        && o_prog_rdata[0] == o_low_volt_detect_en; endproperty
    // sync lag not exact to the cycle, so a three cycle quiet window is required
    property p_stop_sw; o_cfg_locked && !o_hw_watchdog_sel && !$past(i_wdg_active, 2)
        && !$past(i_wdg_active, 3) && !$past(i_wdg_active, 4) |-> o_stop_allowed; endproperty
    property p_stop_hw; o_cfg_locked && o_hw_watchdog_sel && !$past(i_nmi_pin, 2)
        && !$past(i_nmi_pin, 3) && !$past(i_nmi_pin, 4) |-> !o_stop_allowed; endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
    a_static: assert property (p_static) else $error("setting moved");
    a_low_volt_lock: assert property (p_low_volt_lock) else $error("detector early");
    a_rd_idle: assert property (p_rd_idle) else $error("stray rdata");
    a_rd_gate: assert property (p_rd_gate) else $error("read outside mode");
    a_rd_lo: assert property (p_rd_lo) else $error("low byte read");
    a_rd_hi: assert property (p_rd_hi) else $error("reserved bits read");
    a_stop_sw: assert property (p_stop_sw) else $error("stop blocked");
    a_stop_hw: assert property (p_stop_hw) else $error("stop with watchdog");
    c_lock: cover property ($rose(o_cfg_locked));
    c_rd: cover property (rq);
    c_ext: cover property (o_hw_watchdog_sel && o_stop_allowed);
endmodule
bind ocd_option_decoder ocd_props ocd_props_inst (.*);

// File: verilog/ocd_cfg_store.sv
// configuration word store, programmable once per reset
`timescale 1ns/1ps
module ocd_cfg_store
    import ocd_pkg::*;
#(
    parameter bit MASK_ROM = 1'b0
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_prog_mode,
    input  wire logic       i_wr,
    input  wire logic [1:0] i_addr,
    input  wire logic [7:0] i_wdata,
    ocd_cfg_if.store        cfg
);
    logic [15:0] word_ff;
    logic [15:0] nxt_word;
    ocd_state_t  state_ff;
    ocd_state_t  nxt_state;
    wire         wr_ok  = i_prog_mode && i_wr && !MASK_ROM;
    wire         wr_lsb = wr_ok && (i_addr == ADDR_LSB);
    wire         wr_msb = wr_ok && (i_addr == ADDR_MSB);
    always_comb begin
        nxt_word  = word_ff;
        nxt_state = state_ff;
        unique case (state_ff)
            OCD_BLANK: begin
                if (wr_lsb) begin
                    nxt_word[7:0] = i_wdata;
                    nxt_state     = OCD_LOW;
                end
            end
            OCD_LOW: begin
                // upper byte completes the single programming pass
                if (wr_msb) begin
                    nxt_word[15:8] = i_wdata;
                    nxt_state      = OCD_LOCKED;
                end
            end
            OCD_LOCKED: begin
                nxt_word = word_ff;
            end
            default: begin
                nxt_state = OCD_LOCKED;
            end
        endcase
    end
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word_ff  <= MASK_ROM ? CFG_FACTORY : CFG_RESET;
            state_ff <= MASK_ROM ? OCD_LOCKED : OCD_BLANK;
        end else begin
            word_ff  <= nxt_word;
            state_ff <= nxt_state;
        end
    end
    // reserved positions forced low regardless of what the tool wrote
    assign cfg.word   = word_ff & ~CFG_RSVD_MASK;
    assign cfg.locked = (state_ff == OCD_LOCKED);
endmodule

// File: verilog/ocd_option_decoder.sv
// decodes the option configuration word into static device settings
`timescale 1ns/1ps
// Operation
// - sixteen bit word selects hardware configuration
// - word unmapped, reachable only in programming mode
// - word programmable once per reset, later writes ignored
// - mask parts fixed, no read path
// - blank parts ship with all zeros
// - bit 9 allows stop with watchdog while nmi pin is high
// - bit 8 enables low voltage detector
// - bit 7 blocks external program readout
// - bit 6 selects rc oscillator
// - bit 3 enables nmi pin pullup
// - bit 2 enables timer pin pullup
// - bit 1 forces hardware watchdog
// - bit 0 enables oscillator safeguard
module ocd_option_decoder
    import ocd_pkg::*;
#(
    parameter bit MASK_ROM = 1'b0
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_prog_mode,
    input  wire logic       i_prog_wr,
    input  wire logic       i_prog_rd,
    input  wire logic [1:0] i_prog_addr,
    input  wire logic [7:0] i_prog_wdata,
    input  wire logic       i_nmi_pin,
    input  wire logic       i_wdg_active,
    output logic      [7:0] o_prog_rdata,
    output logic            o_cfg_locked,
    output logic            o_stop_allowed,
    output logic            o_low_volt_detect_en,
    output logic            o_readout_protect,
    output logic            o_osc_rc_sel,
    output logic            o_nmi_pin_pullup_en,
    output logic            o_timer_pin_pullup_en,
    output logic            o_hw_watchdog_sel,
    output logic            o_osc_safeguard_en
);
    ocd_cfg_if cfg ();

    ocd_cfg_store #(.MASK_ROM(MASK_ROM)) u_store (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_prog_mode(i_prog_mode),
        .i_wr       (i_prog_wr),
        .i_addr     (i_prog_addr),
        .i_wdata    (i_prog_wdata),
        .cfg        (cfg)
    );

    // pin levels come from outside the clock domain
    logic [1:0] nmi_sync_ff;
    logic [1:0] wdg_sync_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] cfg_bits_ff;
    logic [7:0] nxt_cfg_bits;
    logic       stop_ff;
    logic       locked_ff;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            nmi_sync_ff <= 2'h0;
            wdg_sync_ff <= 2'h0;
        end else begin
            nmi_sync_ff <= {nmi_sync_ff[0], i_nmi_pin};
            wdg_sync_ff <= {wdg_sync_ff[0], i_wdg_active};
        end
    end

    wire        nmi_high  = nmi_sync_ff[1];
    wire        wdg_on    = wdg_sync_ff[1] || cfg.word[BIT_HW_WDG];
    wire        ext_stop  = cfg.word[BIT_EXT_STOP];
    // stop is always fine without a running watchdog
    wire        nxt_stop  = !wdg_on || (ext_stop && nmi_high);
    wire        rd_ok     = i_prog_mode && i_prog_rd && !MASK_ROM;
    wire        rd_lsb    = rd_ok && (i_prog_addr == ADDR_LSB);
    wire        rd_msb    = rd_ok && (i_prog_addr == ADDR_MSB);
    // settings move in programming mode or until locked, so user mode sees them static once locked
    wire        cfg_upd   = i_prog_mode || !cfg.locked;

    assign nxt_rdata = rd_lsb ? cfg.word[7:0] : (rd_msb ? cfg.word[15:8] : 8'h00);
    assign nxt_cfg_bits = cfg_upd ? {cfg.word[BIT_LOW_VOLT],
                                     cfg.word[BIT_PROTECT],
                                     cfg.word[BIT_OSC_RC],
                                     cfg.word[BIT_NMI_PULL],
                                     cfg.word[BIT_TIMER_PULL],
                                     cfg.word[BIT_HW_WDG],
                                     cfg.word[BIT_SAFEGUARD],
                                     1'b0}
                                  : cfg_bits_ff;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_ff    <= 8'h00;
            cfg_bits_ff <= 8'h00;
            stop_ff     <= 1'b0;
            locked_ff   <= 1'b0;
        end else begin
            rdata_ff    <= nxt_rdata;
            cfg_bits_ff <= nxt_cfg_bits;
            stop_ff     <= nxt_stop;
            locked_ff   <= cfg.locked;
        end
    end

    assign o_prog_rdata          = rdata_ff;
    assign o_cfg_locked          = locked_ff;
    assign o_stop_allowed        = stop_ff;
    assign o_low_volt_detect_en  = cfg_bits_ff[7];
    assign o_readout_protect     = cfg_bits_ff[6];
    assign o_osc_rc_sel          = cfg_bits_ff[5];
    assign o_nmi_pin_pullup_en   = cfg_bits_ff[4];
    assign o_timer_pin_pullup_en = cfg_bits_ff[3];
    assign o_hw_watchdog_sel     = cfg_bits_ff[2];
    assign o_osc_safeguard_en    = cfg_bits_ff[1];
endmodule
